/* shared/hfs_pkg.sv */
// Purpose: shared constants and carriers for the hiccup fault sequencer
// Assumes: core_clk at 125 MHz
// Notes: all timing counts derive from printed times and the clock period
package hfs_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int COOL_DOWN_US = 5500;
    localparam int COOL_DOWN_CYC = (COOL_DOWN_US * 1000) / CLK_PERIOD_NS;
    localparam int SOFT_START_US = 3600;
    localparam int SOFT_START_CYC = (SOFT_START_US * 1000) / CLK_PERIOD_NS;
    localparam int UV_FILTER_NS = 7000;
    localparam int UV_FILTER_CYC = (UV_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HS_BLANK_NS = 200;
    localparam int HS_BLANK_CYC = (HS_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LS_SAMPLE_NS = 50;
    localparam int LS_SAMPLE_CYC = (LS_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [4:0] LS_TRIP_COUNT = 5'hF;
    localparam logic [5:0] LS_QUIET_COUNT = 6'h20;
    localparam int TW = 20;
    localparam int RAMP_W = 12;
    localparam logic [RAMP_W-1:0] RAMP_FULL = 12'hFFF;

    typedef enum logic [1:0] {
        HFS_RUN,
        HFS_COOL,
        HFS_SOFT
    } hfs_state_e;

    // comparator results after synchronisation
    typedef struct packed {
        logic ls_over;
        logic hs_over;
        logic uv_low;
    } hfs_cmp_s;

    // gate drive pair
    typedef struct packed {
        logic upper_on;
        logic lower_on;
    } hfs_gate_s;
endpackage : hfs_pkg

/* src/hfs_sync.sv */
// Purpose: two-stage synchroniser for asynchronous comparator levels
// Assumes: single clock, synchronous active-high reset
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
module hfs_sync #(
    parameter int W = 1
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_dout;

    always_comb begin
        next_meta = din;
        next_dout = meta;
        if (reset) begin
            next_meta = '0;
            next_dout = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        meta <= next_meta;
        dout <= next_dout;
    end
endmodule : hfs_sync

/* src/hfs_sequencer.sv */
// Purpose: hiccup fault sequencer for a synchronous buck controller
// Assumes: pwm_high is the modulator's upper-switch request; comparators are async levels
// Notes: reference selector works on digital ramp codes; analog parts are outside
// Functional notes
// - hiccup: both gates off, 5.5 ms cool-down
// - after cool-down, 3.6 ms internal soft-start
// - fifteen low-side over-current samples enter hiccup
// - low-side check sampled once per off interval, 50 ns after its start
// - 32 quiet cycles clear the low-side counter
// - high-side comparator trip enters hiccup immediately
// - under-voltage held 7 us enters hiccup
// - reference is lowest of three sources
// - hiccup keeps external soft-start; lockout discharges
// - hiccup arms timer, discharges internal ramp
// - under-voltage ignored during soft-start
// - high-side comparator blanked 200 ns after turn-on
// - limit cycle skips upper pulse until valley
// - first current sample 50 ns after lower on
`timescale 1ns/1ns
module hfs_sequencer
    import hfs_pkg::*;
#(
    parameter int COOL_CYC = COOL_DOWN_CYC,
    parameter int SOFT_CYC = SOFT_START_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic supply_lockout,
    input wire logic shutdown,
    input wire logic pwm_high,
    input wire logic ls_over_cmp,
    input wire logic hs_over_cmp,
    input wire logic undervoltage_trip,
    input wire logic ext_soft_start_done,
    input wire logic [RAMP_W-1:0] bandgap_code,
    input wire logic [RAMP_W-1:0] ext_ramp_code,
    output hfs_gate_s gate,
    output logic [RAMP_W-1:0] ref_code,
    output logic int_ramp_discharge,
    output logic ext_ramp_discharge,
    output logic hiccup_active
);
    hfs_cmp_s cmp;
    hfs_state_e state, next_state;
    logic [TW-1:0] timer, next_timer;
    logic [RAMP_W-1:0] ramp, next_ramp;
    logic [4:0] ls_count, next_ls_count;
    logic [5:0] quiet, next_quiet;
    logic [TW-1:0] uv_cnt, next_uv_cnt;
    logic [7:0] blank, next_blank;
    logic [7:0] sample, next_sample;
    logic ls_seen, next_ls_seen;
    logic limit_mode, next_limit_mode;
    logic pwm_d, next_pwm_d;
    // previous upper gate level, so a turn-on can be told from a held pulse
    logic up_d, next_up_d;
    logic [TW+RAMP_W-1:0] ramp_prod;
    hfs_gate_s next_gate;
    logic [RAMP_W-1:0] next_ref;
    logic next_int_dis, next_ext_dis, next_hiccup;
    logic off_start, fault_ls, fault_hs, fault_uv, enter;
    logic [RAMP_W-1:0] lo;

    hfs_sync #(.W(3)) i_hfs_sync (
        .core_clk(core_clk),
        .reset(reset),
        .din({ls_over_cmp, hs_over_cmp, undervoltage_trip}),
        .dout(cmp)
    );

    always_comb begin
        next_pwm_d = pwm_high;
        next_up_d = gate.upper_on;
        off_start = pwm_d && !pwm_high;
        // wide product: a real soft-start count times the full code overflows TW bits
        ramp_prod = (TW+RAMP_W)'(TW'(SOFT_CYC) - timer) * (TW+RAMP_W)'(RAMP_FULL);
        // counters start at zero, so a lockout or shutdown restarts everything
        next_state = state;
        next_timer = timer;
        next_ramp = ramp;
        next_ls_count = ls_count;
        next_quiet = quiet;
        next_uv_cnt = uv_cnt;
        next_blank = blank;
        next_sample = sample;
        next_ls_seen = ls_seen;
        next_limit_mode = limit_mode;
        fault_ls = 1'b0;
        // blanking window after each upper turn-on; the turn-on cycle itself is
        // ignored by the up_d term, since the window is only loaded at its end
        if (gate.upper_on && !up_d) begin
            next_blank = 8'(HS_BLANK_CYC);
        end else if (blank != 8'h00) begin
            next_blank = blank - 8'h01;
        end
        fault_hs = cmp.hs_over && gate.upper_on && up_d && (blank == 8'h00);
        // sample low-side current once per off interval, after settle delay
        if (off_start) begin
            next_sample = 8'(LS_SAMPLE_CYC);
            next_ls_seen = 1'b0;
        end else if (sample > 8'h01) begin
            next_sample = sample - 8'h01;
        end else if (sample == 8'h01) begin
            next_sample = 8'h00;
            next_ls_seen = 1'b1;
            if (cmp.ls_over) begin
                next_limit_mode = 1'b1;
                next_quiet = 6'h00;
                if (ls_count == LS_TRIP_COUNT - 5'h01) begin
                    fault_ls = 1'b1;
                    next_ls_count = 5'h00;
                end else begin
                    next_ls_count = ls_count + 5'h01;
                end
            end else begin
                next_limit_mode = 1'b0;
                if (quiet == LS_QUIET_COUNT - 6'h01) begin
                    next_ls_count = 5'h00;
                    next_quiet = 6'h00;
                end else begin
                    next_quiet = quiet + 6'h01;
                end
            end
        end
        // valley reached: limit mode releases the upper switch
        if (limit_mode && ls_seen && !cmp.ls_over) begin
            next_limit_mode = 1'b0;
        end
        if (state == HFS_RUN && ext_soft_start_done && cmp.uv_low) begin
            next_uv_cnt = (uv_cnt == TW'(UV_FILTER_CYC)) ? uv_cnt : uv_cnt + TW'(1);
        end else begin
            next_uv_cnt = '0;
        end
        fault_uv = (uv_cnt == TW'(UV_FILTER_CYC));
        // a fault in soft-start restarts the cool-down; none counts during it
        enter = (state != HFS_COOL) && (fault_ls || fault_hs || fault_uv);
        case (state)
            HFS_RUN: begin
                if (enter) begin
                    next_state = HFS_COOL;
                end
            end
            HFS_COOL: begin
                if (timer == TW'(1)) begin
                    next_state = HFS_SOFT;
                    next_timer = TW'(SOFT_CYC);
                end else begin
                    next_timer = timer - TW'(1);
                end
            end
            HFS_SOFT: begin
                if (enter) begin
                    next_state = HFS_COOL;
                end else if (timer == TW'(1)) begin
                    next_state = HFS_RUN;
                    next_ramp = RAMP_FULL;
                end else begin
                    next_timer = timer - TW'(1);
                    next_ramp = RAMP_W'(ramp_prod / (TW+RAMP_W)'(SOFT_CYC));
                end
            end
            default: next_state = HFS_RUN;
        endcase
        if (enter) begin
            next_timer = TW'(COOL_CYC);
            next_ramp = '0;
            next_ls_count = 5'h00;
            next_quiet = 6'h00;
            next_limit_mode = 1'b0;
        end
        if (reset || supply_lockout || shutdown) begin
            next_state = HFS_RUN;
            next_timer = '0;
            next_ramp = RAMP_FULL;
            next_ls_count = 5'h00;
            next_quiet = 6'h00;
            next_uv_cnt = '0;
            next_blank = 8'h00;
            next_sample = 8'h00;
            next_ls_seen = 1'b0;
            next_limit_mode = 1'b0;
            next_pwm_d = 1'b0;
            next_up_d = 1'b0;
        end
    end

    always_comb begin
        lo = (bandgap_code < ext_ramp_code) ? bandgap_code : ext_ramp_code;
        next_ref = (ramp < lo) ? ramp : lo;
        // gates follow the next state so they drop on the very edge hiccup starts
        next_gate.upper_on = (next_state != HFS_COOL) && pwm_high && !next_limit_mode;
        next_gate.lower_on = (next_state != HFS_COOL) && !next_gate.upper_on;
        next_int_dis = (next_state == HFS_COOL);
        next_ext_dis = supply_lockout || shutdown;
        next_hiccup = (next_state != HFS_RUN);
        if (reset || supply_lockout || shutdown) begin
            next_gate = '0;
            next_ref = '0;
            next_int_dis = 1'b1;
            next_hiccup = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        state <= next_state;
        timer <= next_timer;
        ramp <= next_ramp;
        ls_count <= next_ls_count;
        quiet <= next_quiet;
        uv_cnt <= next_uv_cnt;
        blank <= next_blank;
        sample <= next_sample;
        ls_seen <= next_ls_seen;
        limit_mode <= next_limit_mode;
        pwm_d <= next_pwm_d;
        up_d <= next_up_d;
        gate <= next_gate;
        ref_code <= next_ref;
        int_ramp_discharge <= next_int_dis;
        ext_ramp_discharge <= next_ext_dis;
        hiccup_active <= next_hiccup;
    end
endmodule : hfs_sequencer

/* tb/hfs_sequencer_checker.sv */
// Purpose: port-level assertions for the hiccup fault sequencer
// Assumes: COOL_CYC and SOFT_CYC handed on by the bind
// Notes: helper counters saturate so long hiccups stay legal
`timescale 1ns/1ns
module hfs_sequencer_checker
    import hfs_pkg::*;
#(
    parameter int COOL_CYC = COOL_DOWN_CYC,
    parameter int SOFT_CYC = SOFT_START_CYC
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic supply_lockout,
    input wire logic shutdown,
    input wire logic hs_over_cmp,
    input wire logic [RAMP_W-1:0] bandgap_code,
    input wire logic [RAMP_W-1:0] ext_ramp_code,
    input wire hfs_gate_s gate,
    input wire logic [RAMP_W-1:0] ref_code,
    input wire logic int_ramp_discharge,
    input wire logic ext_ramp_discharge,
    input wire logic hiccup_active
);
    logic [5:0] up_cnt;
    // wide enough to cover a full-length cool-down plus soft-start
    logic [20:0] hc_cnt;
    always_ff @(posedge core_clk) begin
        up_cnt <= (reset || !gate.upper_on) ? 6'h00 : up_cnt + {5'h00, up_cnt != 6'h3F};
        hc_cnt <= (reset || !hiccup_active) ? 21'h0 : hc_cnt + {20'h0, hc_cnt != 21'h1FFFFF};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    a_entry_gates_off: assert property ($rose(hiccup_active) |-> gate == 2'h0)
        else $error("gate on at hiccup entry");
    a_cool_hold: assert property (hiccup_active && hc_cnt < COOL_CYC - 2
        |-> gate == 2'h0 && int_ramp_discharge) else $error("cool-down not held");
    a_entry_discharge: assert property ($rose(hiccup_active) |-> int_ramp_discharge)
        else $error("internal ramp not discharged");
    a_soft_length: assert property ($fell(hiccup_active) && !$past(supply_lockout)
        && !$past(shutdown) |-> $past(hc_cnt) >= COOL_CYC + SOFT_CYC - 3)
        else $error("hiccup ended early");
    a_ext_ramp_kept: assert property (!supply_lockout && !shutdown && !$past(reset)
        && !$past(supply_lockout) && !$past(shutdown) |-> !ext_ramp_discharge)
        else $error("external ramp discharged");
    a_lockout_drain: assert property (supply_lockout || shutdown |=> ext_ramp_discharge)
        else $error("external ramp kept in lockout");
    a_ref_lowest: assert property (!$past(reset) |-> ref_code <= $past(bandgap_code)
        && ref_code <= $past(ext_ramp_code)) else $error("reference not lowest");
    a_hs_trip: assert property ((up_cnt >= 6'h18 && hs_over_cmp)[*3]
        |-> ##[0:4] hiccup_active) else $error("high-side trip missed");
endmodule : hfs_sequencer_checker
bind hfs_sequencer hfs_sequencer_checker #(.COOL_CYC(COOL_CYC), .SOFT_CYC(SOFT_CYC))
    i_hfs_sequencer_checker (.core_clk(core_clk), .reset(reset),
    .supply_lockout(supply_lockout), .shutdown(shutdown), .hs_over_cmp(hs_over_cmp),
    .bandgap_code(bandgap_code), .ext_ramp_code(ext_ramp_code), .gate(gate),
    .ref_code(ref_code), .int_ramp_discharge(int_ramp_discharge),
    .ext_ramp_discharge(ext_ramp_discharge), .hiccup_active(hiccup_active));

/* tb/hfs_fet_model.sv */
// Purpose: behavioural model of the external power switch pair
// Assumes: comparators respond with no delay; only the high-side one follows a switch
// Notes: a short only shows while the upper switch conducts
`timescale 1ns/1ns
module hfs_fet_model
    import hfs_pkg::*;
(
    input wire hfs_gate_s gate,
    input wire logic short_fault,
    input wire logic overload,
    output logic hs_over_cmp,
    output logic ls_over_cmp
);
    assign hs_over_cmp = gate.upper_on & short_fault;
    assign ls_over_cmp = overload;
endmodule : hfs_fet_model

/* tb/test_hiccup_fault_sequencer.sv */
// Purpose: scenario bench for the hiccup fault sequencer
// Assumes: short cool-down and soft-start counts in simulation
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin error_cnt++; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp); end end
module test_hiccup_fault_sequencer
    import hfs_pkg::*;
    ;
    localparam int COOL = 50;
    localparam int SOFT = 40;
    logic core_clk = 0, reset = 1, supply_lockout = 0, shutdown = 0, pwm_high = 0;
    logic undervoltage_trip = 0, ext_soft_start_done = 0, short_fault = 0, overload = 0;
    logic [RAMP_W-1:0] bandgap_code = 12'h9C4, ext_ramp_code = 12'hFFF, ref_code;
    logic ls_over_cmp, hs_over_cmp, int_ramp_discharge, ext_ramp_discharge, hiccup_active;
    hfs_gate_s gate;
    int error_cnt = 0, checks_done = 0, cyc = 0;
    hfs_sequencer #(.COOL_CYC(COOL), .SOFT_CYC(SOFT)) i_hfs_sequencer (.core_clk(core_clk),
        .reset(reset), .supply_lockout(supply_lockout), .shutdown(shutdown),
        .pwm_high(pwm_high), .ls_over_cmp(ls_over_cmp), .hs_over_cmp(hs_over_cmp),
        .undervoltage_trip(undervoltage_trip), .ext_soft_start_done(ext_soft_start_done),
        .bandgap_code(bandgap_code), .ext_ramp_code(ext_ramp_code), .gate(gate),
        .ref_code(ref_code), .int_ramp_discharge(int_ramp_discharge),
        .ext_ramp_discharge(ext_ramp_discharge), .hiccup_active(hiccup_active));
    hfs_fet_model i_hfs_fet_model (.gate(gate), .short_fault(short_fault),
        .overload(overload), .hs_over_cmp(hs_over_cmp), .ls_over_cmp(ls_over_cmp));
    initial forever #4 core_clk = ~core_clk;
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : conclude
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 10000) begin
            error_cnt++;
            conclude();
        end
    end
    task tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task wait_hic(input logic v, input int max);
        for (int i = 0; i < max && hiccup_active !== v; i++) tick(1);
        `CHK(hiccup_active, v)
    endtask : wait_hic
    task pwm_cycle(input logic over);
        overload = over;
        pwm_high = 1;
        tick(4);
        pwm_high = 0;
        tick(12);
    endtask : pwm_cycle
    task t_ls_count;
        overload = 1;
        tick(300);
        `CHK(hiccup_active, 1'b0)
        repeat (14) pwm_cycle(1);
        `CHK(hiccup_active, 1'b0)
        repeat (32) pwm_cycle(0);
        pwm_high = 1;
        tick(2);
        `CHK(gate.upper_on, 1'b1)
        pwm_high = 0;
        tick(12);
        repeat (14) pwm_cycle(1);
        `CHK(hiccup_active, 1'b0)
        pwm_high = 1;
        tick(4);
        `CHK(gate.upper_on, 1'b0)
        pwm_high = 0;
        tick(12);
        `CHK(hiccup_active, 1'b1)
        overload = 0;
        wait_hic(1'b0, 200);
        $display("low-side count test done");
    endtask : t_ls_count
    task t_hs_short(input logic again);
        int n;
        short_fault = 1;
        pwm_high = 1;
        tick(20);
        `CHK(hiccup_active, 1'b0)
        wait_hic(1'b1, 30);
        `CHK(gate, 2'h0)
        `CHK(int_ramp_discharge, 1'b1)
        `CHK(ext_ramp_discharge, 1'b0)
        short_fault = again;
        for (n = 0; n < 300 && hiccup_active === 1'b1; n++) begin
            if (n == COOL + SOFT + 6) short_fault = 0;
            tick(1);
        end
        `CHK(n > COOL + SOFT + 6, again)
        `CHK(n >= COOL + SOFT - 4, 1'b1)
        pwm_high = 0;
        tick(4);
        $display("high-side short test done");
    endtask : t_hs_short
    task t_uv;
        undervoltage_trip = 1;
        tick(UV_FILTER_CYC + 40);
        `CHK(hiccup_active, 1'b0)
        undervoltage_trip = 0;
        tick(3);
        ext_soft_start_done = 1;
        undervoltage_trip = 1;
        tick(UV_FILTER_CYC - 20);
        `CHK(hiccup_active, 1'b0)
        wait_hic(1'b1, 30);
        undervoltage_trip = 0;
        wait_hic(1'b0, 200);
        $display("under-voltage test done");
    endtask : t_uv
    task t_lockout_ref;
        for (int i = 0; i < 2; i++) begin
            bandgap_code = i ? 12'h123 : 12'h800;
            ext_ramp_code = i ? 12'hABC : 12'h3FF;
            tick(3);
            `CHK(ref_code, i ? 12'h123 : 12'h3FF)
            supply_lockout = !i;
            shutdown = i;
            tick(2);
            `CHK(ext_ramp_discharge, 1'b1)
            supply_lockout = 0;
            shutdown = 0;
            tick(3);
            `CHK(ext_ramp_discharge, 1'b0)
        end
        $display("reference and lockout test done");
    endtask : t_lockout_ref
    initial begin
        tick(6);
        reset = 0;
        tick(2);
        t_ls_count();
        t_hs_short(1'b0);
        t_hs_short(1'b1);
        t_uv();
        t_lockout_ref();
        conclude();
    end
endmodule : test_hiccup_fault_sequencer
